// file: design/sis_pkg.sv
// How it works
// - Ready flag sets in phase 2 on ready input
// - Phase 2 drives presenting level and strobe pulse
// - No phase 6 from phase 2 until ready flag set
// - Parity flop toggles per one bit shifted out
// - Indirect indexes address, loads it at T9
// - Indirect clears opcode, keeps counter, stays phase 0
// - Halt, command, no-op: one pulse, then phase 5
// - Halt sets halt flop unless interrupt, stops run
// - Command decodes buffer, I/O, systems from C9-C11
// - Phase 5 recirculates, counter increments, next fetch
// - Logical ops shift operand serially into accumulator
// - Opcodes 14, 16, 17 give AND, OR, XOR
// - Register change bits select A, B, X transfers
// - C14 negates accumulator serially with helper flop
// - C17 stops exchange after low 9 bits
// - Index involved: extend X15 upward, clear at end
// - Shift indexes T23 to T16 only, carry off
// - C10 picks rotate or arithmetic right shift
// - Address cleared T10, loaded T9, pulse suppressed
// - Counter steps two per word, odd flop apart
// - Right shift moves A two places, low bits to B
package sis_pkg;
  // Word and bit timing
  localparam int          WORD_BITS    = 24;
  localparam logic [4:0]  FIRST_PULSE  = 5'h17;   // T23
  localparam logic [4:0]  LAST_PULSE   = 5'h00;   // Final pulse time
  localparam logic [4:0]  INDEX_STOP   = 5'h10;   // T16
  localparam logic [4:0]  ADDR_CLR_BT  = 5'h0A;   // T10
  localparam logic [4:0]  ADDR_LOAD_BT = 5'h09;   // T9
  localparam logic [4:0]  MEM_PULSE_BT = 5'h08;   // T8
  localparam logic [4:0]  EXCH_BITS    = 5'h09;   // Partial exchange width
  // Instruction word fields (C0 is bit 23)
  localparam int OPC_LSB  = 15;                   // Opcode at C3..C8
  localparam int IDX_BIT  = 23;                   // C0 index tag
  localparam int C9_BIT   = 14;
  localparam int C10_BIT  = 13;
  localparam int C11_BIT  = 12;
  localparam int XEXT_BIT = 8;                    // X15
  // Opcodes
  localparam logic [5:0] OP_HALT = 6'h00;
  localparam logic [5:0] OP_CMD  = 6'h02;
  localparam logic [5:0] OP_POUT = 6'h0B;         // Octal 13
  localparam logic [5:0] OP_AND  = 6'h0C;         // Octal 14
  localparam logic [5:0] OP_OR   = 6'h0E;         // Octal 16
  localparam logic [5:0] OP_XOR  = 6'h0F;         // Octal 17
  localparam logic [5:0] OP_NOP  = 6'h10;         // Octal 20
  localparam logic [5:0] OP_EXU  = 6'h13;         // Octal 23
  localparam logic [5:0] OP_RCH  = 6'h26;         // Octal 46
  localparam logic [5:0] OP_RSH  = 6'h36;         // Octal 66
  // Register map, byte offsets
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_INSTR = 5'h04;
  localparam logic [4:0] REG_FETCH = 5'h08;
  localparam logic [4:0] REG_ACC   = 5'h0C;
  localparam logic [4:0] REG_EXT   = 5'h10;
  localparam logic [4:0] REG_IDX   = 5'h14;
  localparam logic [4:0] REG_ADDR  = 5'h18;
  localparam logic [4:0] REG_PC    = 5'h1C;
  // Control bits
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_CLRHT = 1;
  // Phases
  typedef enum logic [2:0] {PH_IDLE, PH_0, PH_1, PH_2, PH_3, PH_5, PH_6}
    sis_phase_t;
  // Command strobes toward devices and buffer
  typedef struct packed {
    logic cmd;
    logic sysComm;
    logic ioCtl;
    logic bufCtl;
  } sis_cmd_t;
endpackage

// file: design/sis_sequencer.sv
`timescale 1ns/1ns
module sis_sequencer (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [4:0]        avAddress,
  input  wire logic              avRead,
  input  wire logic              avWrite,
  input  wire logic [31:0]       avWritedata,
  output logic [31:0]            avReaddata,
  output logic                   avWaitrequest,
  // Peripheral side
  input  wire logic              outReady,
  input  wire logic              interruptActive,
  output logic                   outPresent,
  output logic                   outStrobe,
  output logic                   outData,
  output sis_pkg::sis_cmd_t      cmdOut,
  output logic                   memPulse
);
  // Sequencer state
  sis_pkg::sis_phase_t state, next_state;
  logic [4:0]  bitTime, next_bitTime;            // Pulse counter, 23 to 0
  logic [5:0]  opReg, next_opReg;                // Opcode register
  logic [23:0] cReg, next_cReg;                  // Operand register
  logic [23:0] fetchWord, next_fetchWord;        // Word fetched by indirect
  logic [23:0] aReg, next_aReg;                  // Accumulator
  logic [23:0] bReg, next_bReg;                  // Extension
  logic [23:0] xReg, next_xReg;                  // Index
  logic [13:0] addrReg, next_addrReg;            // Address / shift counter
  logic [13:0] pc, next_pc;                      // Program counter
  logic        running, next_running;            // Run flop
  logic        halt_flop, next_halt_flop;
  logic        transfer_ready_flag, next_transfer_ready_flag;
  logic        parity_check_flop, next_parity_check_flop;
  logic        negate_helper_flop, next_negate_helper_flop;
  logic        index_extend_flop, next_index_extend_flop;
  logic        shift_mode_flop, next_shift_mode_flop;
  logic        odd_count_flop, next_odd_count_flop;
  logic [4:0]  exchCount, next_exchCount;        // Exchanged bit count
  // Registered outputs
  logic        next_outPresent, next_outStrobe, next_outData, next_memPulse;
  sis_pkg::sis_cmd_t next_cmdOut;
  logic [31:0] next_avReaddata;
  logic        next_avWaitrequest;

  // Decode helpers
  logic        access, isLast, isLogic, isShort, opcFetched;
  logic [23:0] shiftedA, shiftedB;
  logic [13:0] idxAddr;
  logic        aBit, bBit, xBit, logicBit;
  logic        srcA, srcB, srcX;

  // One access completes in the cycle waitrequest is low
  assign access  = (avRead | avWrite) & ~avWaitrequest;
  assign isLast  = (bitTime == sis_pkg::LAST_PULSE);
  assign isLogic = (opReg == sis_pkg::OP_AND) | (opReg == sis_pkg::OP_OR)
                 | (opReg == sis_pkg::OP_XOR);
  assign isShort = (opReg == sis_pkg::OP_HALT) | (opReg == sis_pkg::OP_CMD)
                 | (opReg == sis_pkg::OP_NOP) | (opReg == sis_pkg::OP_RCH);
  assign opcFetched = 1'b0;

  // Indexed address; shift indexes only the low eight bits
  always_comb begin
    if (!cReg[sis_pkg::IDX_BIT]) begin
      idxAddr = cReg[13:0];
    end else if (opReg == sis_pkg::OP_RSH) begin
      // Carry forced off past T16 keeps the modifiers intact
      idxAddr = {cReg[13:8], 8'(cReg[7:0] + xReg[7:0])};
    end else begin
      idxAddr = 14'(cReg[13:0] + xReg[13:0]);
    end
  end

  // Bitwise combine of accumulator and operand
  always_comb begin
    unique case (opReg)
      sis_pkg::OP_AND: logicBit = aReg[0] & cReg[0];
      sis_pkg::OP_OR:  logicBit = aReg[0] | cReg[0];
      default:         logicBit = aReg[0] ^ cReg[0];
    endcase
  end

  // Double right shift per word; rotate pulls B low bits, else sign fill
  always_comb begin
    if (shift_mode_flop) begin
      shiftedA = {bReg[1:0], aReg[23:2]};
    end else begin
      shiftedA = {{2{aReg[23]}}, aReg[23:2]};
    end
    shiftedB = {aReg[1:0], bReg[23:2]};
  end

  // Serial register change sources, C14..C23 at word bits 9..0
  always_comb begin
    srcA = cReg[3] | cReg[7] | cReg[9] | cReg[0];
    srcB = cReg[1] | cReg[2] | cReg[5];
    srcX = cReg[4] | cReg[8];
    aBit = (cReg[3] & bReg[0]) | (cReg[7] & xReg[0])
         | (cReg[9] & (aReg[0] ^ negate_helper_flop));
    bBit = (cReg[2] & aReg[0]) | (cReg[5] & xReg[0]);
    xBit = (cReg[4] & bReg[0]) | (cReg[8] & aReg[0]);
    if (!srcA) begin
      aBit = aReg[0];
    end
    if (!srcB) begin
      bBit = bReg[0];
    end
    if (!srcX) begin
      xBit = xReg[0];
    end
    if (index_extend_flop) begin
      xBit = xReg[23];
    end
  end

  // Next-state logic for the whole sequencer and register file
  always_comb begin
    next_state = state;
    next_bitTime = (bitTime == sis_pkg::LAST_PULSE) ? sis_pkg::FIRST_PULSE
                                                     : 5'(bitTime - 5'h01);
    next_opReg = opReg;
    next_cReg = cReg;
    next_fetchWord = fetchWord;
    next_aReg = aReg;
    next_bReg = bReg;
    next_xReg = xReg;
    next_addrReg = addrReg;
    next_pc = pc;
    next_running = running;
    next_halt_flop = halt_flop;
    next_transfer_ready_flag = transfer_ready_flag;
    next_parity_check_flop = parity_check_flop;
    next_negate_helper_flop = negate_helper_flop;
    next_index_extend_flop = index_extend_flop;
    next_shift_mode_flop = shift_mode_flop;
    next_odd_count_flop = odd_count_flop;
    next_exchCount = exchCount;
    // Software control first, so hardware halt set and run stop win below
    if (access && avWrite && avAddress == sis_pkg::REG_CTRL) begin
      next_running = avWritedata[sis_pkg::CTRL_RUN];
      if (avWritedata[sis_pkg::CTRL_CLRHT]) begin
        next_halt_flop = 1'b0;
      end
    end
    unique case (state)
      sis_pkg::PH_IDLE: begin
        next_bitTime = sis_pkg::FIRST_PULSE;
      end
      sis_pkg::PH_0: begin
        // Memory pulse at T8 except for shifts and one-pulse opcodes
        if (bitTime == sis_pkg::ADDR_LOAD_BT) begin
          next_addrReg = idxAddr;
        end
        if (opReg == sis_pkg::OP_RSH) begin
          if (bitTime == sis_pkg::ADDR_CLR_BT) begin
            next_addrReg = '0;
          end else if (bitTime == sis_pkg::ADDR_LOAD_BT) begin
            // Count field only; modifier bits must not reach the counter
            next_addrReg = {8'h00, idxAddr[5:1], 1'b0};
            next_odd_count_flop = idxAddr[0];
            next_shift_mode_flop = cReg[sis_pkg::C10_BIT];
            next_state = sis_pkg::PH_1;
            next_bitTime = sis_pkg::FIRST_PULSE;
          end
        end else if (isShort) begin
          // One pulse only, then a full word in phase 5
          next_state = sis_pkg::PH_5;
          next_bitTime = sis_pkg::FIRST_PULSE;
          next_exchCount = '0;
        end else if (isLast) begin
          if (opReg == sis_pkg::OP_EXU) begin
            // Opcode cleared, new word decoded; counter left alone
            next_opReg = fetchWord[sis_pkg::OPC_LSB +: 6];
            next_cReg = fetchWord;
          end else if (opReg == sis_pkg::OP_POUT) begin
            // Output word arrives from memory at the last pulse
            next_cReg = fetchWord;
            next_state = sis_pkg::PH_2;
            next_transfer_ready_flag = 1'b0;
          end else if (isLogic) begin
            next_cReg = fetchWord;
            next_state = sis_pkg::PH_6;
          end else begin
            next_state = sis_pkg::PH_IDLE;
          end
        end
      end
      sis_pkg::PH_1: begin
        // Memory idle; the address register now serves as counter
        if (isLast) begin
          next_state = sis_pkg::PH_3;
        end
      end
      sis_pkg::PH_3: begin
        if (isLast) begin
          if (addrReg[13:1] != '0) begin
            next_aReg = shiftedA;
            next_bReg = shiftedB;
            next_addrReg = {13'(addrReg[13:1] - 13'h0001), 1'b0};
          end else if (odd_count_flop) begin
            // Remaining odd place moves by one
            next_aReg = {shift_mode_flop ? bReg[0] : aReg[23], aReg[23:1]};
            next_bReg = {aReg[0], bReg[23:1]};
            next_odd_count_flop = 1'b0;
          end else begin
            next_pc = 14'(pc + 14'h0001);
            next_state = sis_pkg::PH_IDLE;
          end
        end
      end
      sis_pkg::PH_2: begin
        // Operand register holds still while waiting
        if (outReady) begin
          next_transfer_ready_flag = 1'b1;
        end
        if (isLast && transfer_ready_flag) begin
          next_state = sis_pkg::PH_6;
          next_parity_check_flop = 1'b0;
        end
      end
      sis_pkg::PH_5: begin
        // Operand register does not shift here
        if (opReg == sis_pkg::OP_HALT && !interruptActive) begin
          next_halt_flop = 1'b1;
        end
        if (opReg == sis_pkg::OP_RCH) begin
          next_aReg = {aBit, aReg[23:1]};
          next_bReg = {bBit, bReg[23:1]};
          next_xReg = {xBit, xReg[23:1]};
          if (cReg[9] && aReg[0]) begin
            next_negate_helper_flop = 1'b1;
          end
          next_exchCount = 5'(exchCount + 5'h01);
          if (cReg[6] && exchCount == 5'(sis_pkg::EXCH_BITS - 5'h01)) begin
            next_cReg = '0;
            next_index_extend_flop = srcX;
          end
        end
        if (isLast) begin
          next_pc = 14'(pc + 14'h0001);
          next_negate_helper_flop = 1'b0;
          next_index_extend_flop = 1'b0;
          next_state = sis_pkg::PH_IDLE;
          if (halt_flop || next_halt_flop) begin
            next_running = 1'b0;
          end
        end
      end
      sis_pkg::PH_6: begin
        next_cReg = {cReg[0], cReg[23:1]};
        if (isLogic) begin
          next_aReg = {logicBit, aReg[23:1]};
        end else if (cReg[0]) begin
          next_parity_check_flop = ~parity_check_flop;
        end
        if (isLast) begin
          next_pc = 14'(pc + 14'h0001);
          next_state = sis_pkg::PH_IDLE;
        end
      end
      default: next_state = sis_pkg::PH_IDLE;
    endcase
    // Software writes; fetch word at any time, other datapath registers only while idle
    if (access && avWrite) begin
      unique case (avAddress)
        sis_pkg::REG_INSTR: begin
          if (state == sis_pkg::PH_IDLE && running) begin
            next_cReg = avWritedata[23:0];
            next_opReg = avWritedata[sis_pkg::OPC_LSB +: 6];
            next_state = sis_pkg::PH_0;
            next_bitTime = sis_pkg::FIRST_PULSE;
          end
        end
        sis_pkg::REG_FETCH: next_fetchWord = avWritedata[23:0];
        sis_pkg::REG_ACC:   if (state == sis_pkg::PH_IDLE) next_aReg = avWritedata[23:0];
        sis_pkg::REG_EXT:   if (state == sis_pkg::PH_IDLE) next_bReg = avWritedata[23:0];
        sis_pkg::REG_IDX:   if (state == sis_pkg::PH_IDLE) next_xReg = avWritedata[23:0];
        default: ;
      endcase
    end
  end

  // Output and bus answer computation; present, strobe and command from the coming state
  always_comb begin
    next_outPresent = (next_state == sis_pkg::PH_2);
    // Strobe is one pulse time at the head of each phase 2 word
    next_outStrobe = next_outPresent && next_bitTime == sis_pkg::FIRST_PULSE;
    next_outData = (state == sis_pkg::PH_6) && !isLogic && cReg[0];
    next_memPulse = (state == sis_pkg::PH_0) && (bitTime == sis_pkg::MEM_PULSE_BT)
                  && (opReg != sis_pkg::OP_RSH);
    next_cmdOut.cmd = (next_state == sis_pkg::PH_5) && (opReg == sis_pkg::OP_CMD);
    next_cmdOut.bufCtl = next_cmdOut.cmd && !cReg[sis_pkg::C10_BIT]
                       && !cReg[sis_pkg::C11_BIT];
    next_cmdOut.ioCtl = next_cmdOut.cmd && !cReg[sis_pkg::C10_BIT]
                      && cReg[sis_pkg::C11_BIT];
    next_cmdOut.sysComm = next_cmdOut.cmd && !cReg[sis_pkg::C9_BIT]
                        && cReg[sis_pkg::C10_BIT] && cReg[sis_pkg::C11_BIT];
    // Waitrequest drops for exactly one cycle per request
    next_avWaitrequest = !((avRead || avWrite) && avWaitrequest);
    next_avReaddata = avReaddata;
    if ((avRead || avWrite) && avWaitrequest) begin
      unique case (avAddress)
        sis_pkg::REG_CTRL:  next_avReaddata = {24'h000000, 3'(state), opcFetched,
                                               parity_check_flop, transfer_ready_flag,
                                               halt_flop, running};
        sis_pkg::REG_INSTR: next_avReaddata = {8'h00, cReg};
        sis_pkg::REG_FETCH: next_avReaddata = {8'h00, fetchWord};
        sis_pkg::REG_ACC:   next_avReaddata = {8'h00, aReg};
        sis_pkg::REG_EXT:   next_avReaddata = {8'h00, bReg};
        sis_pkg::REG_IDX:   next_avReaddata = {8'h00, xReg};
        sis_pkg::REG_ADDR:  next_avReaddata = {18'h00000, addrReg};
        sis_pkg::REG_PC:    next_avReaddata = {18'h00000, pc};
        default:            next_avReaddata = 32'h00000000;
      endcase
    end
  end

  // All state registers; synchronous reset to constants
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sis_pkg::PH_IDLE;
      bitTime <= sis_pkg::FIRST_PULSE;
      opReg <= '0;
      cReg <= '0;
      fetchWord <= '0;
      aReg <= '0;
      bReg <= '0;
      xReg <= '0;
      addrReg <= '0;
      pc <= '0;
      running <= 1'b0;
      halt_flop <= 1'b0;
      transfer_ready_flag <= 1'b0;
      parity_check_flop <= 1'b0;
      negate_helper_flop <= 1'b0;
      index_extend_flop <= 1'b0;
      shift_mode_flop <= 1'b0;
      odd_count_flop <= 1'b0;
      exchCount <= '0;
      outPresent <= 1'b0;
      outStrobe <= 1'b0;
      outData <= 1'b0;
      memPulse <= 1'b0;
      cmdOut <= '0;
      avReaddata <= 32'h00000000;
      avWaitrequest <= 1'b1;
    end else begin
      state <= next_state;
      bitTime <= next_bitTime;
      opReg <= next_opReg;
      cReg <= next_cReg;
      fetchWord <= next_fetchWord;
      aReg <= next_aReg;
      bReg <= next_bReg;
      xReg <= next_xReg;
      addrReg <= next_addrReg;
      pc <= next_pc;
      running <= next_running;
      halt_flop <= next_halt_flop;
      transfer_ready_flag <= next_transfer_ready_flag;
      parity_check_flop <= next_parity_check_flop;
      negate_helper_flop <= next_negate_helper_flop;
      index_extend_flop <= next_index_extend_flop;
      shift_mode_flop <= next_shift_mode_flop;
      odd_count_flop <= next_odd_count_flop;
      exchCount <= next_exchCount;
      outPresent <= next_outPresent;
      outStrobe <= next_outStrobe;
      outData <= next_outData;
      memPulse <= next_memPulse;
      cmdOut <= next_cmdOut;
      avReaddata <= next_avReaddata;
      avWaitrequest <= next_avWaitrequest;
    end
  end

  // Checks
  chk_ready_phase: assert property (@(posedge clk) disable iff (rst)
    $rose(transfer_ready_flag) |-> $past(state) == sis_pkg::PH_2 && $past(outReady))
    else $error("ready flag set outside phase 2");
  chk_present_phase: assert property (@(posedge clk) disable iff (rst)
    outPresent |-> state == sis_pkg::PH_2)
    else $error("output present outside phase 2");
  chk_wait_ready: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_2 && !transfer_ready_flag |=> state != sis_pkg::PH_6)
    else $error("phase 6 entered without ready");
  chk_parity_toggle: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_6 && opReg == sis_pkg::OP_POUT && cReg[0]
    |=> parity_check_flop != $past(parity_check_flop))
    else $error("parity flop missed a one bit");
  chk_exu_stay: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_0 && opReg == sis_pkg::OP_EXU && isLast
    |=> state == sis_pkg::PH_0 && pc == $past(pc))
    else $error("indirect left phase 0 or moved counter");
  chk_short_ph5: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_0 && isShort |=> state == sis_pkg::PH_5 ##1
    (state == sis_pkg::PH_5)[*8])
    else $error("short opcode did not hold phase 5");
  chk_halt_stop: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_5 && opReg == sis_pkg::OP_HALT && !interruptActive && isLast
    |=> !running && halt_flop)
    else $error("halt did not stop the run flop");
  chk_cmd_decode: assert property (@(posedge clk) disable iff (rst)
    cmdOut.bufCtl |-> cmdOut.cmd && !cmdOut.ioCtl && !cmdOut.sysComm)
    else $error("command decode overlap");
  chk_shift_enter: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_0 && opReg == sis_pkg::OP_RSH && bitTime == sis_pkg::ADDR_LOAD_BT
    |=> state == sis_pkg::PH_1 ##[1:30] state == sis_pkg::PH_3)
    else $error("shift did not pass through phase 1");
  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    state == sis_pkg::PH_3 && isLast && addrReg[13:1] != '0
    |=> addrReg[13:1] == 13'($past(addrReg[13:1]) - 13'h0001))
    else $error("shift counter step wrong");
endmodule // sis_sequencer

// file: test/sis_periph.sv
`timescale 1ns/1ns
// Peripheral model: answers parallel output after a chosen delay
module sis_periph (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Handshake from sequencer
  input  wire logic       outPresent,
  input  wire logic [3:0] delay,
  // Ready toward sequencer
  output logic            outReady
);
  logic [3:0] cnt; // Cycles since data presented
  // Ready rises late, never before data is presented
  always @(posedge clk) begin
    if (rst || !outPresent) begin
      cnt <= 4'h0;
      outReady <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      outReady <= (cnt >= delay);
    end
  end
endmodule // sis_periph

// file: test/serial_cpu_instruction_sequencer_tb.sv
`timescale 1ns/1ns
module serial_cpu_instruction_sequencer_tb;
  logic clk = 0, rst = 1, avRead = 0, avWrite = 0, outReady, intAct = 0;
  logic [4:0] avAddress = 5'h00;
  logic [31:0] avWritedata = 32'h0, avReaddata, rd, pc;
  logic avWaitrequest, outPresent, outStrobe, outData, memPulse;
  logic [3:0] dly = 4'h0, seenCmd;
  logic seenPres, seenStb, seenMem, seenClr = 1'b0;
  sis_pkg::sis_cmd_t cmdOut;
  int n_mismatch = 0, checks_done = 0, cyc = 0, nOnes = 0;
  sis_sequencer uut (.clk(clk), .rst(rst), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
    .avWaitrequest(avWaitrequest), .outReady(outReady), .interruptActive(intAct),
    .outPresent(outPresent), .outStrobe(outStrobe), .outData(outData),
    .cmdOut(cmdOut), .memPulse(memPulse));
  sis_periph per (.clk(clk), .rst(rst), .outPresent(outPresent), .delay(dly),
    .outReady(outReady));
  // Clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end
  // Sticky record of strobes seen during one instruction; one driver only
  always @(posedge clk) begin
    if (seenClr) begin
      seenCmd <= 4'h0;
      seenPres <= 1'b0;
      seenStb <= 1'b0;
      seenMem <= 1'b0;
      nOnes <= 0;
    end else begin
      seenCmd <= seenCmd | cmdOut;
      seenPres <= seenPres | outPresent;
      seenStb <= seenStb | outStrobe;
      seenMem <= seenMem | memPulse;
      nOnes <= nOnes + int'(outData);
    end
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest sampled low
  task av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avWrite <= w;
    avRead <= !w;
    avAddress <= a;
    avWritedata <= d;
    do @(posedge clk); while (avWaitrequest !== 1'b0);
    q = avReaddata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
  endtask
  // Start an instruction and poll until the sequencer is idle
  task run_op(input logic [5:0] op, input logic [23:0] low);
    int i;
    seenClr <= 1'b1;
    av(1, sis_pkg::REG_CTRL, 32'h1, rd);
    seenClr <= 1'b0;
    av(1, sis_pkg::REG_INSTR, {8'h00, low | (24'(op) << sis_pkg::OPC_LSB)}, rd);
    for (i = 0; i < 200; i++) begin
      av(0, sis_pkg::REG_CTRL, 32'h0, rd);
      if (rd[7:5] === 3'h0) break;
    end
    check(32'(rd[7:5]), 32'h0, "not idle");
  endtask
  task t_logic;
    logic [5:0] ops[3];
    logic [23:0] e[3];
    int k;
    ops = '{sis_pkg::OP_AND, sis_pkg::OP_OR, sis_pkg::OP_XOR};
    e = '{24'h00F000, 24'hFFFF0F, 24'hFF0F0F};
    for (k = 0; k < 3; k++) begin
      av(1, sis_pkg::REG_ACC, 32'h00FF0F, rd);
      av(1, sis_pkg::REG_FETCH, 32'hFFF000, rd);
      run_op(ops[k], 24'h0);
      av(0, sis_pkg::REG_ACC, 32'h0, rd);
      check(rd, {8'h00, e[k]}, "logic result");
      check(32'(seenMem), 32'h1, "memory pulse");
    end
  endtask
  task t_nop;
    av(0, sis_pkg::REG_PC, 32'h0, pc);
    run_op(sis_pkg::OP_NOP, 24'h0);
    av(0, sis_pkg::REG_PC, 32'h0, rd);
    check(rd, {18'h0, pc[13:0] + 14'h1}, "nop pc");
  endtask
  task t_cmd;
    logic [23:0] c[3];
    logic [3:0] e[3];
    int k;
    c = '{24'h000000, 24'h001000, 24'h003000};
    e = '{4'h9, 4'hA, 4'hC};
    for (k = 0; k < 3; k++) begin
      run_op(sis_pkg::OP_CMD, c[k]);
      check(32'(seenCmd), 32'(e[k]), "command decode");
    end
  endtask
  task t_halt;
    intAct <= 1'b1;
    run_op(sis_pkg::OP_HALT, 24'h0);
    check(32'(rd[1]), 32'h0, "halt under interrupt");
    intAct <= 1'b0;
    run_op(sis_pkg::OP_HALT, 24'h0);
    check(32'(rd[1:0]), 32'h2, "halt stops run");
    av(1, sis_pkg::REG_CTRL, 32'h2, rd);
  endtask
  task t_pout;
    dly <= 4'h9;
    av(1, sis_pkg::REG_FETCH, 32'h00001F, rd);
    run_op(sis_pkg::OP_POUT, 24'h0);
    check(32'({seenPres, seenStb}), 32'h3, "present and strobe");
    check(32'(rd[3]), 32'h1, "parity of output word");
    check(32'(nOnes), 32'h5, "serial output ones");
    dly <= 4'h0;
  endtask
  task t_rch;
    av(1, sis_pkg::REG_ACC, 32'h123456, rd);
    av(1, sis_pkg::REG_EXT, 32'h654321, rd);
    run_op(sis_pkg::OP_RCH, 24'h000008);
    av(0, sis_pkg::REG_ACC, 32'h0, rd);
    check(rd, 32'h654321, "B to A");
  endtask
  task t_exu;
    av(1, sis_pkg::REG_IDX, 32'h000010, rd);
    av(1, sis_pkg::REG_FETCH, {8'h00, 24'(sis_pkg::OP_NOP) << sis_pkg::OPC_LSB}, rd);
    av(0, sis_pkg::REG_PC, 32'h0, pc);
    run_op(sis_pkg::OP_EXU, 24'h800123);
    av(0, sis_pkg::REG_ADDR, 32'h0, rd);
    check(rd, 32'h000133, "indexed address");
    av(0, sis_pkg::REG_PC, 32'h0, rd);
    check(rd, {18'h0, pc[13:0] + 14'h1}, "executed pc");
  endtask
  task t_shift;
    av(1, sis_pkg::REG_ACC, 32'h123456, rd);
    av(1, sis_pkg::REG_EXT, 32'h654321, rd);
    run_op(sis_pkg::OP_RSH, 24'h002004);
    check(32'(seenMem), 32'h0, "memory pulse in shift");
    av(0, sis_pkg::REG_ACC, 32'h0, rd);
    check(rd, 32'h112345, "rotate A");
    av(0, sis_pkg::REG_EXT, 32'h0, rd);
    check(rd, 32'h665432, "rotate B");
    av(1, sis_pkg::REG_ACC, 32'h812345, rd);
    av(1, sis_pkg::REG_EXT, 32'h0, rd);
    run_op(sis_pkg::OP_RSH, 24'h000001);
    av(0, sis_pkg::REG_ACC, 32'h0, rd);
    check(rd, 32'hC091A2, "odd shift A");
    av(0, sis_pkg::REG_EXT, 32'h0, rd);
    check(rd, 32'h800000, "odd shift B");
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_nop();
    t_logic();
    t_cmd();
    t_halt();
    t_pout();
    t_exu();
    t_rch();
    t_shift();
    test_done();
  end
endmodule // serial_cpu_instruction_sequencer_tb
